// ### logic/spw_pkg.sv
// Function
// - enable bit turns module and pins on
// - halt bit stops module in idle mode
// - overflow flag set on lost received word
// - tx full set on write, cleared on move
// - rx full set on receive, cleared on read
// - master clock disable frees clock pin
// - data out disable releases data pin
// - width bit picks 16 or 8 bits
// - master samples at end or middle
// - edge bit picks output change edge
// - framed mode ignores edge select bit
// - select enable makes non-framed slave use select pin
// - polarity bit sets clock idle level
// - role bit picks clock master or slave
// - framed enable turns sync pulse on select pin
// - sync direction picks input or output
// - sync polarity picks active high or low
// - sync early select places pulse timing
// - master clock is clock over both prescalers
// - overflow drops word and freezes until flag cleared
// - master transfer starts on buffer write
// - completion and error events are raised
package spw_pkg;

	// ***********************************************
	// register map
	// ***********************************************
	localparam logic [7:0]  ADDR_STAT = 8'h00;
	localparam logic [7:0]  ADDR_CON1 = 8'h04;
	localparam logic [7:0]  ADDR_CON2 = 8'h08;
	localparam logic [7:0]  ADDR_DATA = 8'h0C;

	localparam int BIT_EN     = 15;
	localparam int BIT_SIDL   = 13;
	localparam int BIT_ROV    = 6;
	localparam int BIT_TBF    = 1;
	localparam int BIT_RBF    = 0;

	localparam int BIT_CLKOFF = 12;
	localparam int BIT_DATOFF = 11;
	localparam int BIT_WIDE   = 10;
	localparam int BIT_LATE   = 9;
	localparam int BIT_CKE    = 8;
	localparam int BIT_SELEN  = 7;
	localparam int BIT_POLAR  = 6;
	localparam int BIT_MST    = 5;
	localparam int SEC_HI     = 4;
	localparam int SEC_LO     = 2;
	localparam int PRI_HI     = 1;
	localparam int PRI_LO     = 0;

	localparam int BIT_FRAME  = 15;
	localparam int BIT_FSD    = 14;
	localparam int BIT_FPOL   = 13;
	localparam int BIT_FDLY   = 1;

	localparam logic [15:0] CON1_MASK  = 16'h1FFF;
	localparam logic [15:0] CON2_MASK  = 16'hE002;
	localparam logic [15:0] CON1_RST   = 16'h0000;
	localparam logic [15:0] CON2_RST   = 16'h0000;
	localparam logic [15:0] DATA_RST   = 16'h0000;

	// ***********************************************
	// timing
	// ***********************************************
	localparam logic [5:0]  EDGES_BYTE = 6'h10;
	localparam logic [5:0]  EDGES_WORD = 6'h20;
	localparam logic [5:0]  EDGES_PRE  = 6'h02;
	localparam logic [2:0]  SEC_BASE   = 3'h0;
	localparam logic [1:0]  PRI_BASE   = 2'h3;

	// ***********************************************
	// types
	// ***********************************************
	typedef enum logic [1:0] {SPW_IDLE, SPW_PRE, SPW_SHIFT} spw_state_e;

	typedef struct packed {
		logic sck;
		logic sdi;
		logic ss;
	} spw_pin_in_s;

	typedef struct packed {
		logic sck_o;
		logic sck_oe_n;
		logic sdo_o;
		logic sdo_oe_n;
		logic ss_o;
		logic ss_oe_n;
	} spw_pin_out_s;

endpackage

// ### logic/spw_spi_port.sv
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module spw_spi_port (
	input  wire logic                  pclk,      // 50 MHz bus clock
	input  wire logic                  presetn,   // async reset, low
	input  wire logic                  psel,      // apb select
	input  wire logic                  penable,   // apb access phase
	input  wire logic                  pwrite,    // apb direction
	input  wire logic [7:0]            paddr,     // apb byte address
	input  wire logic [31:0]           pwdata,    // apb write data
	output logic [31:0]                prdata,    // apb read data
	output logic                       pready,    // apb ready
	output logic                       pslverr,   // apb error
	input  wire logic                  idle_mode, // device in idle mode
	input  wire spw_pkg::spw_pin_in_s  pin_in,    // pin levels
	output spw_pkg::spw_pin_out_s      pin_out,   // pin drives
	output logic                       xfer_done, // transfer complete pulse
	output logic                       xfer_err   // overflow pulse
);
	import spw_pkg::*;

	// ***********************************************
	// pin synchronisers
	// ***********************************************
	logic [2:0] s1_reg;
	logic [2:0] s2_reg;
	logic       sck_prev_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_reg       <= 3'h0;
			s2_reg       <= 3'h0;
			sck_prev_reg <= 1'b0;
		end else begin
			s1_reg       <= {pin_in.sck, pin_in.sdi, pin_in.ss};
			s2_reg       <= s1_reg;
			sck_prev_reg <= s2_reg[2];
		end
	end

	logic sck_s;
	logic sdi_s;
	logic ss_s;
	assign sck_s = s2_reg[2];
	assign sdi_s = s2_reg[1];
	assign ss_s  = s2_reg[0];

	// ***********************************************
	// state
	// ***********************************************
	logic        en_reg,   en_next;
	logic        sidl_reg, sidl_next;
	logic        rov_reg,  rov_next;
	logic        tbf_reg,  tbf_next;
	logic        rbf_reg,  rbf_next;
	logic [15:0] con1_reg, con1_next;
	logic [15:0] con2_reg, con2_next;
	logic [15:0] txb_reg,  txb_next;
	logic [15:0] rxb_reg,  rxb_next;
	logic [15:0] sh_reg,   sh_next;
	logic [15:0] acc_reg,  acc_next;
	logic [5:0]  edge_reg, edge_next;
	logic [8:0]  div_reg,  div_next;
	logic        ph_reg,   ph_next;
	logic        done_reg, done_next;
	logic        err_reg,  err_next;
	spw_state_e  st_reg,   st_next;

	// ***********************************************
	// decode of configuration
	// ***********************************************
	logic       run, mst, wide, framed, fr_slave, fr_master, cke_eff;
	logic       late_eff, sel_en, sel_off, sync_act;
	logic [9:0] period;
	logic [8:0] half;
	logic [3:0] sec_ratio;
	logic [6:0] pri_ratio;
	logic [5:0] last_edge;

	assign run       = en_reg & ~(sidl_reg & idle_mode);
	assign mst       = con1_reg[BIT_MST];
	assign wide      = con1_reg[BIT_WIDE];
	assign framed    = con2_reg[BIT_FRAME];
	assign fr_slave  = framed & con2_reg[BIT_FSD];
	assign fr_master = framed & ~con2_reg[BIT_FSD];
	// edge select has no meaning once framing is on
	assign cke_eff   = con1_reg[BIT_CKE] & ~framed;
	// slaves always sample mid-bit; the phase bit counts only for masters
	assign late_eff  = mst & con1_reg[BIT_LATE];
	assign sel_en    = con1_reg[BIT_SELEN] & ~mst & ~framed;
	assign sel_off   = sel_en & ss_s;
	assign sync_act  = (ss_s == con2_reg[BIT_FPOL]);
	assign last_edge = (wide ? EDGES_WORD : EDGES_BYTE) - 6'h01;

	// descending codes: all ones is the fastest ratio
	assign sec_ratio = 4'h8 - {1'b0, con1_reg[SEC_HI:SEC_LO] - SEC_BASE};
	assign pri_ratio = 7'h01 << {(PRI_BASE - con1_reg[PRI_HI:PRI_LO]), 1'b0};
	// ten bits: 64:1 times 8:1 is 512 and must not wrap to zero
	assign period    = 10'(pri_ratio * sec_ratio);
	// odd periods round the half period down; 1:1 overall is clamped to 2
	assign half      = (period[9:1] == 9'h000) ? 9'h001 : period[9:1];

	// ***********************************************
	// register bus
	// ***********************************************
	logic acc_ph, wr_en, rd_en, hit;
	assign acc_ph  = psel & penable;
	assign wr_en   = acc_ph & pwrite;
	assign rd_en   = acc_ph & ~pwrite;
	assign hit     = (paddr == ADDR_STAT) | (paddr == ADDR_CON1)
	               | (paddr == ADDR_CON2) | (paddr == ADDR_DATA);
	// zero wait states keep the cpu view of the flags exact
	assign pready  = 1'b1;
	assign pslverr = acc_ph & ~hit;

	always_comb begin
		prdata = 32'h0000_0000;
		unique case (paddr)
			ADDR_STAT: begin
				prdata[BIT_EN]   = en_reg;
				prdata[BIT_SIDL] = sidl_reg;
				prdata[BIT_ROV]  = rov_reg;
				prdata[BIT_TBF]  = tbf_reg;
				prdata[BIT_RBF]  = rbf_reg;
			end
			ADDR_CON1: prdata[15:0] = con1_reg;
			ADDR_CON2: prdata[15:0] = con2_reg;
			ADDR_DATA: prdata[15:0] = rxb_reg;
			default:   prdata = 32'h0000_0000;
		endcase
	end

	// ***********************************************
	// serial engine
	// ***********************************************
	logic tick, ev, lead, chg, samp_now, fin, start, rov_clr, rd_data;

	always_comb begin
		en_next   = en_reg;
		sidl_next = sidl_reg;
		con1_next = con1_reg;
		con2_next = con2_reg;
		txb_next  = txb_reg;
		tbf_next  = tbf_reg;
		rbf_next  = rbf_reg;
		rxb_next  = rxb_reg;
		sh_next   = sh_reg;
		acc_next  = acc_reg;
		edge_next = edge_reg;
		div_next  = div_reg;
		ph_next   = ph_reg;
		st_next   = st_reg;
		done_next = 1'b0;
		err_next  = 1'b0;
		rov_clr   = 1'b0;
		rd_data   = rd_en & (paddr == ADDR_DATA);

		if (wr_en) begin
			unique case (paddr)
				ADDR_STAT: begin
					en_next   = pwdata[BIT_EN];
					sidl_next = pwdata[BIT_SIDL];
					rov_clr   = ~pwdata[BIT_ROV];
				end
				ADDR_CON1: con1_next = pwdata[15:0] & CON1_MASK;
				// bit 0 of the second control word is not stored
				ADDR_CON2: con2_next = pwdata[15:0] & CON2_MASK;
				ADDR_DATA: begin
					txb_next = pwdata[15:0];
					tbf_next = 1'b1;
				end
				default: ;
			endcase
		end
		if (rd_data) begin
			rbf_next = 1'b0;
		end

		// master bit clock is a half-period tick, held off in idle state
		tick = mst & ~con1_reg[BIT_CLKOFF] & (div_reg == half - 9'h001);
		if (st_reg == SPW_IDLE || tick) begin
			div_next = 9'h000;
		end else begin
			div_next = div_reg + 9'h001;
		end

		// overflow freezes the engine until software writes the flag bit to 0 in the status word
		ev = (st_reg != SPW_IDLE) & ~rov_reg
		   & (mst ? tick : ((sck_s ^ sck_prev_reg) & ~sel_off));
		lead    = ~edge_reg[0];
		chg     = cke_eff ? (~lead & (edge_reg != last_edge))
		                  : (lead & (edge_reg != 6'h00));
		// the extra closing half period of a master is no mid-bit sample
		samp_now = late_eff
		         ? (cke_eff ? ~lead
		                    : ((lead & edge_reg != 6'h00)
		                       | (edge_reg == last_edge + 6'h01)))
		         : (cke_eff ? (lead & (edge_reg <= last_edge))
		                    : ~lead);
		fin     = mst ? (edge_reg == last_edge + 6'h01)
		              : (edge_reg == last_edge);

		// master waits for data; a framed slave waits for the sync pulse
		start = run & ~rov_reg & (~mst | tbf_reg)
		      & (~fr_slave | sync_act) & ~sel_off;

		unique case (st_reg)
			SPW_IDLE: begin
				edge_next = 6'h00;
				ph_next   = 1'b0;
				if (start) begin
					if (tbf_reg) begin
						sh_next  = txb_reg;
						// a word written in this cycle keeps the buffer full
						tbf_next = wr_en & (paddr == ADDR_DATA);
					end
					acc_next = 16'h0000;
					// early sync spends one bit clock before the data
					st_next  = (framed & ~con2_reg[BIT_FDLY])
					         ? SPW_PRE : SPW_SHIFT;
				end
			end
			SPW_PRE: begin
				if (ev) begin
					ph_next   = ~ph_reg;
					edge_next = edge_reg + 6'h01;
					if (edge_reg == EDGES_PRE - 6'h01) begin
						edge_next = 6'h00;
						st_next   = SPW_SHIFT;
					end
				end
			end
			SPW_SHIFT: begin
				if (ev) begin
					edge_next = edge_reg + 6'h01;
					if (edge_reg <= last_edge) begin
						ph_next = ~ph_reg;
					end
					if (samp_now) begin
						acc_next = {acc_reg[14:0], sdi_s};
					end
					if (chg) begin
						sh_next = {sh_reg[14:0], 1'b0};
					end
					if (fin) begin
						st_next   = SPW_IDLE;
						done_next = 1'b1;
						if (rbf_reg && !rd_data) begin
							err_next = 1'b1;
						end else begin
							rxb_next = wide ? (samp_now
							         ? {acc_reg[14:0], sdi_s} : acc_reg)
							         : {8'h00, (samp_now
							         ? {acc_reg[6:0], sdi_s} : acc_reg[7:0])};
							rbf_next = 1'b1;
						end
					end
				end
			end
		endcase

		// a deselected slave drops its partial word
		if (!run || sel_off) begin
			st_next   = SPW_IDLE;
			edge_next = 6'h00;
			ph_next   = 1'b0;
		end

		// the overflow event wins over a clear in the same cycle
		rov_next = err_next | (rov_reg & ~rov_clr);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_reg   <= 1'b0;
			sidl_reg <= 1'b0;
			rov_reg  <= 1'b0;
			tbf_reg  <= 1'b0;
			rbf_reg  <= 1'b0;
			con1_reg <= CON1_RST;
			con2_reg <= CON2_RST;
			txb_reg  <= DATA_RST;
			rxb_reg  <= DATA_RST;
			sh_reg   <= DATA_RST;
			acc_reg  <= DATA_RST;
			edge_reg <= 6'h00;
			div_reg  <= 9'h000;
			ph_reg   <= 1'b0;
			done_reg <= 1'b0;
			err_reg  <= 1'b0;
			st_reg   <= SPW_IDLE;
		end else begin
			en_reg   <= en_next;
			sidl_reg <= sidl_next;
			rov_reg  <= rov_next;
			tbf_reg  <= tbf_next;
			rbf_reg  <= rbf_next;
			con1_reg <= con1_next;
			con2_reg <= con2_next;
			txb_reg  <= txb_next;
			rxb_reg  <= rxb_next;
			sh_reg   <= sh_next;
			acc_reg  <= acc_next;
			edge_reg <= edge_next;
			div_reg  <= div_next;
			ph_reg   <= ph_next;
			done_reg <= done_next;
			err_reg  <= err_next;
			st_reg   <= st_next;
		end
	end

	// ***********************************************
	// pin drive
	// ***********************************************
	logic sync_out;
	assign sync_out = fr_master & ((st_reg == SPW_PRE)
	                | ((st_reg == SPW_SHIFT) & con2_reg[BIT_FDLY]
	                   & (edge_reg < EDGES_PRE)));

	assign pin_out.sck_o    = con1_reg[BIT_POLAR] ^ ph_reg;
	assign pin_out.sck_oe_n = ~(en_reg & mst
	                          & ~con1_reg[BIT_CLKOFF]);
	assign pin_out.sdo_o    = wide ? sh_reg[15] : sh_reg[7];
	assign pin_out.sdo_oe_n = ~(en_reg & ~con1_reg[BIT_DATOFF]
	                          & ~sel_off);
	assign pin_out.ss_o     = con2_reg[BIT_FPOL] ? sync_out : ~sync_out;
	assign pin_out.ss_oe_n  = ~(en_reg & fr_master);
	assign xfer_done        = done_reg;
	assign xfer_err         = err_reg;

endmodule // spw_spi_port
`default_nettype wire

// ### sim/spw_spi_port_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module spw_spi_port_monitor (
	input wire logic                  pclk,      // bus clock
	input wire logic                  presetn,   // reset, low
	input wire logic                  psel,      // select
	input wire logic                  penable,   // access phase
	input wire logic                  pwrite,    // direction
	input wire logic [7:0]            paddr,     // address
	input wire logic [31:0]           pwdata,    // write data
	input wire logic [31:0]           prdata,    // read data
	input wire logic                  pslverr,   // bus error
	input wire logic                  idle_mode, // device idle
	input wire spw_pkg::spw_pin_out_s pin_out,   // pin drives
	input wire logic                  xfer_done, // done pulse
	input wire logic                  xfer_err   // overflow pulse
);
	import spw_pkg::*;
	// ********
	// shadow of the settings software wrote: {rov, halt, en, con1}
	// ********
	logic [18:0] sh_reg;
	logic [18:0] sh_next;
	wire logic        wr_acc = psel && penable && pwrite;
	wire logic [15:0] cfg    = sh_reg[15:0];
	wire logic        en     = sh_reg[16];
	always_comb begin
		sh_next = sh_reg;
		if (wr_acc && paddr == ADDR_CON1) begin
			sh_next[15:0] = pwdata[15:0];
		end
		if (wr_acc && paddr == ADDR_STAT) begin
			sh_next[17:16] = {pwdata[BIT_SIDL], pwdata[BIT_EN]};
			sh_next[18] = sh_reg[18] && pwdata[BIT_ROV];
		end
		// a new overflow wins over a clearing write
		if (xfer_err) begin
			sh_next[18] = 1'b1;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sh_reg <= '0;
		end else begin
			sh_reg <= sh_next;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ********
	// checks
	// ********
	a_err_has_done: assert property (xfer_err |-> xfer_done)
		else $error("overflow without done");
	a_done_single: assert property (xfer_done |=> !xfer_done)
		else $error("done too long");
	a_sck_half: assert property ($changed(pin_out.sck_o) && en
		&& cfg[4:0] == 5'h1D |=> $stable(pin_out.sck_o) [*7])
		else $error("clock half period short");
	a_idle_level: assert property (xfer_done && cfg[5] && !cfg[12]
		|-> pin_out.sck_o == cfg[6]) else $error("clock idle level");
	a_master_drive: assert property (en && cfg[5] && !cfg[12]
		&& $stable(sh_reg[16:0]) |-> !pin_out.sck_oe_n)
		else $error("master clock not driven");
	a_sck_off: assert property (en && cfg[5] && cfg[12]
		&& $stable(sh_reg[16:0]) |-> pin_out.sck_oe_n)
		else $error("clock pin not released");
	a_sdo_off: assert property (en && cfg[11]
		&& $stable(sh_reg[16:0]) |-> pin_out.sdo_oe_n)
		else $error("data pin not released");
	a_halt_freeze: assert property (en && sh_reg[17] && idle_mode
		&& $past(idle_mode) |-> $stable(pin_out.sck_o) && !xfer_done)
		else $error("runs in idle");
	a_rov_read: assert property (psel && penable && !pwrite
		&& paddr == ADDR_STAT && !xfer_err |-> prdata[6] == sh_reg[18])
		else $error("overflow flag");
	c_word: cover property (xfer_done && cfg[10]);
	c_ovf: cover property (xfer_err);
	c_bad: cover property (pslverr);
endmodule // spw_spi_port_monitor
bind spw_spi_port spw_spi_port_monitor i_mon (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
	.idle_mode(idle_mode), .pin_out(pin_out), .xfer_done(xfer_done),
	.xfer_err(xfer_err));
`default_nettype wire

// ### sim/spw_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// far peripheral: takes data on rising clock, changes on falling, msb first
// ********
module spw_slave_model (
	input  wire logic sck, // clock from the port
	input  wire logic sdo, // data from the port
	output logic      sdi  // data to the port
);
	logic [15:0] tx_sr;
	logic [15:0] rx_sr;
	assign sdi = tx_sr[15];
	always @(posedge sck) begin
		rx_sr <= {rx_sr[14:0], sdo};
	end
	always @(negedge sck) begin
		tx_sr <= {tx_sr[14:0], 1'b0};
	end
endmodule // spw_slave_model
`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import spw_pkg::*;
	logic         pclk, presetn, psel, penable, pwrite, idle_mode;
	logic [7:0]   paddr;
	logic [31:0]  pwdata, prdata, r;
	logic         pready, pslverr, xfer_done, xfer_err, sdi_w, e, hit, err;
	spw_pin_in_s  pin_in;
	spw_pin_out_s pin_out;
	int           miscompares, checks, cycles;
	// clock line pulled down, data line pulled up when released
	wire logic sck_w = !pin_out.sck_oe_n && pin_out.sck_o;
	wire logic sdo_w = pin_out.sdo_oe_n || pin_out.sdo_o;
	assign pin_in = {sck_w, sdi_w, 1'b1};
	spw_spi_port i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.idle_mode(idle_mode), .pin_in(pin_in), .pin_out(pin_out),
		.xfer_done(xfer_done), .xfer_err(xfer_err));
	spw_slave_model i_peer (.sck(sck_w), .sdo(sdo_w), .sdi(sdi_w));
	always #10 pclk = ~pclk;
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			final_report();
		end
	end
	task automatic final_report();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %h expected %h", $time, got, exp);
		end
	endtask
	// ********
	// bus cycles
	// ********
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// only the bench timeout ends a wait for the slave's answer
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		cmp(r, x);
	endtask
	task automatic wdone(input int lim);
		hit = 1'b0;
		err = 1'b0;
		for (int n = 0; n < lim && !hit; n++) begin
			@(posedge pclk);
			hit = (xfer_done === 1'b1);
			err = err | (xfer_err === 1'b1);
		end
	endtask
	task automatic xfer(input logic [31:0] cfg, input logic [15:0] tx, pat);
		wr(ADDR_CON1, cfg);
		i_peer.tx_sr = pat;
		i_peer.rx_sr = 16'h0000;
		wr(ADDR_DATA, {16'h0000, tx});
		wdone(2000);
		cmp({31'h0, hit}, 32'h1);
		rd(ADDR_STAT, 32'h8001);
		rd(ADDR_DATA, cfg[10] ? pat : pat[15:8]);
		rd(ADDR_STAT, 32'h8000);
		cmp(i_peer.rx_sr & (cfg[10] ? 16'hFFFF : 16'h00FF), tx);
	endtask
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		idle_mode = 1'b0;
		i_peer.tx_sr = 16'h0000;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(ADDR_STAT, 32'h0);
		cmp({pin_out.sck_oe_n, pin_out.sdo_oe_n}, 32'h3);
		wr(ADDR_CON1, 32'hFFFF);
		rd(ADDR_CON1, 32'h1FFF);
		wr(ADDR_CON2, 32'hE002);
		rd(ADDR_CON2, 32'hE002);
		wr(ADDR_CON2, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		cmp(e, 32'h1);
		// prescale 16:1 and 1:1 gives eight clocks a half period
		wr(ADDR_STAT, 32'h8000);
		xfer(32'h013D, 16'h003C, 16'hA500);
		xfer(32'h053D, 16'hC3A9, 16'h1234);
		xfer(32'h073D, 16'h5A0F, 16'h8E71);
		wr(ADDR_CON1, 32'h193D);
		repeat (2) @(posedge pclk);
		cmp({pin_out.sck_oe_n, pin_out.sdo_oe_n}, 32'h3);
		wr(ADDR_CON1, 32'h017D);
		repeat (12) @(posedge pclk);
		cmp({pin_out.sck_oe_n, pin_out.sck_o}, 32'h1);
		wr(ADDR_CON1, 32'h013D);
		wr(ADDR_STAT, 32'hA000);
		idle_mode <= 1'b1;
		i_peer.tx_sr = 16'h6600;
		wr(ADDR_DATA, 32'h0055);
		wdone(200);
		cmp(hit, 32'h0);
		idle_mode <= 1'b0;
		wdone(2000);
		cmp(hit, 32'h1);
		rd(ADDR_DATA, 32'h66);
		// second word lands while the first is unread
		i_peer.tx_sr = 16'h9900;
		wr(ADDR_DATA, 32'h0011);
		wdone(2000);
		wr(ADDR_DATA, 32'h0022);
		wdone(2000);
		cmp({hit, err}, 32'h3);
		rd(ADDR_STAT, 32'hA041);
		rd(ADDR_DATA, 32'h99);
		wr(ADDR_STAT, 32'hA000);
		rd(ADDR_STAT, 32'hA000);
		wr(ADDR_STAT, 32'h0);
		wr(ADDR_DATA, 32'h0077);
		rd(ADDR_STAT, 32'h0002);
		// slave setup keeps sample phase and edge select clear
		wr(ADDR_CON1, 32'h0000);
		wr(ADDR_STAT, 32'h8000);
		cmp({pin_out.sck_oe_n, pin_out.sdo_oe_n}, 32'h2);
		rd(ADDR_STAT, 32'h8000);
		wr(ADDR_CON2, 32'h8000);
		cmp({pin_out.ss_oe_n, pin_out.ss_o}, 32'h1);
		final_report();
	end
endmodule // tb
`default_nettype wire
